// File: pkg/ssr_pkg.sv
// ssr_pkg: register map, field positions, reset values and carrier types
// for the synchronous slave serial receiver.
// assumes a 32-bit apb slave with byte addresses and one word per register.
package ssr_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00; // receive_control_reg
   localparam logic [7:0] OFF_BUF = 8'h04;  // serial_buffer_reg, read only
   localparam logic [7:0] OFF_STAT = 8'h08; // serial_status_reg, read only
   localparam logic [7:0] OFF_CLR = 8'h0C;  // status clear, write only
   localparam logic [7:0] OFF_IEN = 8'h10;  // interrupt enable

   // receive_control_reg fields
   localparam int CTRL_EN_BIT = 7;  // receive_enable_bit
   localparam int CTRL_LEN_BIT = 0; // 0: eight data bits, 1: seven data bits
   localparam logic [7:0] CTRL_RST = 8'h00;

   // frame lengths
   localparam logic [3:0] LEN_LONG = 4'h8;
   localparam logic [3:0] LEN_SHORT = 4'h7;

   // status and enable field positions
   localparam int ST_DONE_BIT = 0; // receive complete
   localparam int ST_OVR_BIT = 1;  // overrun error
   localparam logic [1:0] STAT_RST = 2'h0;
   localparam logic [1:0] IEN_RST = 2'h0;
   localparam logic [7:0] BUF_RST = 8'h00;

   // events that land in the status register together
   typedef struct packed {
      logic ovr;  // overrun error
      logic done; // receive complete
   } ssr_evt_t;

   // frame progress
   typedef enum logic [0:0] {
      SSR_IDLE,
      SSR_SHIFT
   } ssr_state_t;

endpackage

// File: rtl/ssr_pin_sync.sv
// ssr_pin_sync: two flip-flop synchroniser for a group of pin levels.
// assumes inputs are asynchronous to clk; only the second stage is visible.
`timescale 1ns/1ps
`default_nettype none
module ssr_pin_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk,               // cpu clock
   input wire logic rst_n,             // async reset, active low
   input wire logic [WIDTH-1:0] d_in,  // raw pin levels
   output logic [WIDTH-1:0] q_out      // synchronised levels
);

   logic [WIDTH-1:0] meta_r; // first stage, read only by the second
   logic [WIDTH-1:0] q_r;    // second stage

   // both stages shift every edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d_in;
         q_r <= meta_r;
      end
   end

   assign q_out = q_r;

endmodule
`default_nettype wire

// File: rtl/ssr_receiver.sv
// ssr_receiver: synchronous slave mode receive path with apb registers.
// assumes an external master drives rx_clock_pin and rx_data_pin, and the
// cpu core pulses instr_start_strobe for one clk at each instruction start.
`timescale 1ns/1ps
`default_nettype none
module ssr_receiver (
   input wire logic clk,                // cpu clock, 40 mhz
   input wire logic rst_n,              // async reset, active low
   input wire logic psel,               // apb select
   input wire logic penable,            // apb access phase
   input wire logic pwrite,             // apb direction
   input wire logic [7:0] paddr,        // apb byte address
   input wire logic [31:0] pwdata,      // apb write data
   output logic [31:0] prdata,          // apb read data
   output logic pready,                 // apb ready
   output logic pslverr,                // apb error on unmapped address
   input wire logic rx_clock_pin,       // external receive clock
   input wire logic rx_data_pin,        // external receive data
   input wire logic instr_start_strobe, // instruction start pulse
   output logic rx_complete,            // receive complete pulse
   output logic irq                     // level interrupt
);

   // synchronised pins
   logic [1:0] pins_s; // synchroniser output, clock above data
   logic clk_s; // receive clock after synchroniser
   logic dat_s; // receive data after synchroniser

   // receive state
   ssr_pkg::ssr_state_t st_r, st_nxt; // frame progress
   logic [3:0] cnt_r, cnt_nxt;        // bits taken in this frame
   logic [7:0] sr_r, sr_nxt;          // receive shift register
   logic samp_r, samp_nxt;            // data level sampled while clock low
   logic clk_prev_r, clk_prev_nxt;    // previous synchronised clock
   logic pend_r, pend_nxt;            // completion waiting for strobe
   logic povr_r, povr_nxt;            // overrun waiting for strobe
   logic unread_r, unread_nxt;        // buffer holds an unread word
   logic done_r, done_nxt;            // receive complete pulse
   logic [7:0] buf_r, buf_nxt;        // serial_buffer_reg

   // software registers
   logic [7:0] ctrl_r, ctrl_nxt;          // receive_control_reg
   ssr_pkg::ssr_evt_t stat_r, stat_nxt;   // serial_status_reg
   logic [1:0] ien_r, ien_nxt;            // interrupt enable
   logic [31:0] prdata_r, prdata_nxt;     // registered read data

   // decoded strobes
   logic en;        // receive enable bit
   logic sh;        // internal receive shift clock
   logic last;      // this shift ends the frame
   logic [7:0] sr_in; // shift register with the new bit
   logic wr_acc;    // apb write taken this edge
   logic rd_buf;    // apb read of the buffer taken this edge
   logic setup;     // apb setup cycle
   logic mapped;    // address decodes to a register
   ssr_pkg::ssr_evt_t evt; // events posted to status this cycle

   // frame length from the control register
   function automatic logic [3:0] frame_len(input logic [7:0] c);
      frame_len = c[ssr_pkg::CTRL_LEN_BIT] ? ssr_pkg::LEN_SHORT : ssr_pkg::LEN_LONG;
   endfunction

   // address decode, used for write accept and error
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == ssr_pkg::OFF_CTRL) || (a == ssr_pkg::OFF_BUF) ||
         (a == ssr_pkg::OFF_STAT) || (a == ssr_pkg::OFF_CLR) ||
         (a == ssr_pkg::OFF_IEN);
   endfunction

   // cast two raw bits to the event layout
   function automatic ssr_pkg::ssr_evt_t ssr_evt_cast(input logic [1:0] b);
      ssr_evt_cast = b;
   endfunction

   // pin synchroniser for clock and data
   ssr_pin_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d_in({rx_clock_pin, rx_data_pin}),
      .q_out(pins_s)
   );

   // split the synchronised pair; nothing reads the raw pins
   assign clk_s = pins_s[1];
   assign dat_s = pins_s[0];

   // shared decode
   always_comb begin
      en = ctrl_r[ssr_pkg::CTRL_EN_BIT];
      sh = en && clk_s && !clk_prev_r;
      last = (cnt_r == frame_len(ctrl_r) - 4'h1);
      sr_in = {samp_r, sr_r[7:1]};
      setup = psel && !penable;
      mapped = is_mapped(paddr);
      wr_acc = psel && penable && pwrite && mapped;
      rd_buf = psel && penable && !pwrite && (paddr == ssr_pkg::OFF_BUF);
   end

   // receive path next state
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      sr_nxt = sr_r;
      samp_nxt = samp_r;
      clk_prev_nxt = clk_s;
      pend_nxt = pend_r;
      povr_nxt = povr_r;
      unread_nxt = unread_r;
      done_nxt = 1'b0;
      buf_nxt = buf_r;
      evt = '0;
      // data is only looked at while the clock is low
      if (!clk_s) begin
         samp_nxt = dat_s;
      end
      // software reading the buffer releases it
      if (rd_buf) begin
         unread_nxt = 1'b0;
      end
      // completion is shown at the next instruction start
      if (pend_r && instr_start_strobe) begin
         done_nxt = 1'b1;
         pend_nxt = 1'b0;
         povr_nxt = 1'b0;
         evt.done = 1'b1;
         evt.ovr = povr_r;
      end
      if (!en) begin
         // disabled: any partial frame is dropped
         st_nxt = ssr_pkg::SSR_IDLE;
         cnt_nxt = 4'h0;
      end else if (sh) begin
         sr_nxt = sr_in;
         unique case (st_r)
            ssr_pkg::SSR_IDLE: begin
               // first clock of a frame
               st_nxt = ssr_pkg::SSR_SHIFT;
            end
            ssr_pkg::SSR_SHIFT: begin
               st_nxt = ssr_pkg::SSR_SHIFT;
            end
         endcase
         if (last) begin
            // frame done: move word out, keep the enable bit
            st_nxt = ssr_pkg::SSR_IDLE;
            cnt_nxt = 4'h0;
            buf_nxt = ctrl_r[ssr_pkg::CTRL_LEN_BIT] ? {1'b0, sr_in[7:1]} : sr_in;
            unread_nxt = 1'b1;
            pend_nxt = 1'b1;
            // unread word is overwritten and flagged
            povr_nxt = unread_r && !rd_buf;
         end else begin
            cnt_nxt = cnt_r + 4'h1;
         end
      end
   end

   // receive path registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ssr_pkg::SSR_IDLE;
         cnt_r <= 4'h0;
         sr_r <= 8'h00;
         samp_r <= 1'b0;
         clk_prev_r <= 1'b0;
         pend_r <= 1'b0;
         povr_r <= 1'b0;
         unread_r <= 1'b0;
         done_r <= 1'b0;
         buf_r <= ssr_pkg::BUF_RST;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sr_r <= sr_nxt;
         samp_r <= samp_nxt;
         clk_prev_r <= clk_prev_nxt;
         pend_r <= pend_nxt;
         povr_r <= povr_nxt;
         unread_r <= unread_nxt;
         done_r <= done_nxt;
         buf_r <= buf_nxt;
      end
   end

   // software registers next state
   always_comb begin
      ctrl_nxt = ctrl_r;
      ien_nxt = ien_r;
      stat_nxt = stat_r;
      prdata_nxt = prdata_r;
      // writes take effect in the access phase
      if (wr_acc) begin
         unique case (paddr)
            ssr_pkg::OFF_CTRL: ctrl_nxt = pwdata[7:0];
            ssr_pkg::OFF_IEN: ien_nxt = pwdata[1:0];
            ssr_pkg::OFF_CLR: stat_nxt = stat_r & ~ssr_evt_cast(pwdata[1:0]);
            default: ctrl_nxt = ctrl_r;
         endcase
      end
      // a new event wins over a clear in the same cycle
      stat_nxt = stat_nxt | evt;
      // read data is fetched in the setup cycle
      if (setup) begin
         prdata_nxt = 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               ssr_pkg::OFF_CTRL: prdata_nxt = {24'h000000, ctrl_r};
               ssr_pkg::OFF_BUF: prdata_nxt = {24'h000000, buf_r};
               ssr_pkg::OFF_STAT: prdata_nxt = {30'h0, stat_r};
               ssr_pkg::OFF_IEN: prdata_nxt = {30'h0, ien_r};
               default: prdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   // software registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= ssr_pkg::CTRL_RST;
         ien_r <= ssr_pkg::IEN_RST;
         stat_r <= ssr_pkg::STAT_RST;
         prdata_r <= 32'h0000_0000;
      end else begin
         ctrl_r <= ctrl_nxt;
         ien_r <= ien_nxt;
         stat_r <= stat_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // outputs: zero wait slave, error only on unmapped access phase
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_r;
   assign rx_complete = done_r;
   assign irq = |(stat_r & ien_r);

   // checks on the receive path
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // first shift of a frame counts one bit
   chk_first_bit: assert property (
      (sh && st_r == ssr_pkg::SSR_IDLE && !last) |=> (cnt_r == 4'h1)
   ) else $error("first shift did not count one bit");

   // a shift never happens while the synchronised clock is held
   chk_shift_edge: assert property (
      $stable(clk_s) |=> $stable(sr_r)
   ) else $error("shift register moved without a rising clock");

   // the sample follows the data pin while the clock is low
   chk_sample_low: assert property (
      (!clk_s) |=> (samp_r == $past(dat_s))
   ) else $error("data not sampled while clock low");

   // sampled bit enters at the top, lsb first
   chk_lsb_first: assert property (
      sh |=> (sr_r[7] == $past(samp_r)) && (sr_r[6:0] == $past(sr_r[7:1]))
   ) else $error("shift did not take sampled bit");

   // frame end marks buffer and pending, leaves the enable set
   chk_frame_end: assert property (
      (sh && last) |=> unread_r && pend_r && en && (cnt_r == 4'h0)
   ) else $error("frame end not handled");

   // completion pulse only at a strobe with a pending frame
   chk_done_strobe: assert property (
      rx_complete |-> $past(instr_start_strobe) && $past(pend_r)
   ) else $error("receive complete without strobe");

   // overrun reaches status together with completion
   chk_overrun_flag: assert property (
      (pend_r && povr_r && instr_start_strobe) |=> stat_r.ovr && stat_r.done
   ) else $error("overrun not posted");

   // receiver idles while disabled
   chk_disabled_idle: assert property (
      (!en) |=> (cnt_r == 4'h0) && (st_r == ssr_pkg::SSR_IDLE)
   ) else $error("receiver active while disabled");

   // count never passes the frame length
   chk_count_bound: assert property (
      cnt_r < frame_len(ctrl_r) || $changed(ctrl_r) || $past(wr_acc)
   ) else $error("bit count beyond frame length");

   // interrupt follows the enabled done status bit
   chk_irq_level: assert property (
      (stat_r.done && ien_r[ssr_pkg::ST_DONE_BIT]) |-> irq
   ) else $error("interrupt missing");

endmodule
`default_nettype wire

// File: testbench/ssr_master_model.sv
// ssr_master_model: external synchronous master driving receive clock and data.
// assumes a 200 ns link period; the clock idles high and stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module ssr_master_model (
   output logic rx_clock_pin, // link clock to the receiver
   output logic rx_data_pin   // serial data to the receiver
);
   // idle levels before the first frame
   initial begin
      rx_clock_pin = 1'b1;
      rx_data_pin = 1'b1;
   end

   // one frame, lsb first, data changed on the falling clock and inverted after the last bit
   task automatic send_frame(input logic [7:0] value, input int nbits);
      #3;
      for (int i = 0; i < nbits; i++) begin
         rx_clock_pin = 1'b0; // falling edge starts each bit
         rx_data_pin = value[i]; // lowest bit first
         #100;
         rx_clock_pin = 1'b1; // data held through the high half
         #100;
      end
      rx_data_pin = ~rx_data_pin; // released line shows no stale bit
   endtask
endmodule
`default_nettype wire

// File: testbench/ssr_receiver_tb_top.sv
// ssr_receiver_tb_top: self-checking bench for the slave receive path.
// assumes the apb map of ssr_pkg and a master model on the link pins.
`timescale 1ns/1ps
`default_nettype none
module ssr_receiver_tb_top;
   logic clk = 1'b0; // cpu clock
   logic rst_n = 1'b0; // reset, active low
   logic psel = 1'b0; // apb select
   logic penable = 1'b0; // apb access
   logic pwrite = 1'b0; // apb direction
   logic [7:0] paddr = 8'h00; // apb address
   logic [31:0] pwdata = 32'h0; // apb write data
   logic [31:0] prdata; // apb read data
   logic pready; // apb ready
   logic pslverr; // apb error
   wire logic rx_clock_pin; // link clock
   wire logic rx_data_pin; // link data
   logic instr_start_strobe = 1'b0; // instruction start pulse
   logic rx_complete; // receive complete pulse
   logic irq; // interrupt
   logic [1:0] strobe_cnt = 2'h0; // strobe spacing
   logic last_err; // pslverr of last transfer
   logic [31:0] rd; // last read word
   int failures = 0; // mismatches
   int n_checks = 0; // comparisons

   // 40 mhz clock
   always #12.5 clk = ~clk;

   // strobe every fourth clock
   always @(posedge clk) begin
      strobe_cnt <= strobe_cnt + 2'h1;
      instr_start_strobe <= (strobe_cnt == 2'h3);
   end

   ssr_receiver u_ssr_receiver (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_clock_pin(rx_clock_pin), .rx_data_pin(rx_data_pin),
      .instr_start_strobe(instr_start_strobe), .rx_complete(rx_complete), .irq(irq));

   ssr_master_model u_ssr_master_model (.rx_clock_pin(rx_clock_pin),
      .rx_data_pin(rx_data_pin));

   // one apb transfer: setup, access until pready, then release
   task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // compare one value
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // read a register and compare
   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
      apb_xfer(1'b0, addr, 32'h0);
      check($sformatf("reg %h", addr), exp, rd);
   endtask

   // bounded wait for the completion pulse
   task automatic wait_done();
      int n;
      n = 0;
      while (rx_complete !== 1'b1 && n < 60) begin
         @(posedge clk);
         n++;
      end
      check("rx_complete", 32'h1, {31'h0, rx_complete});
      @(posedge clk);
   endtask

   // verdict and end of run
   task automatic wrap_up();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      #500000;
      failures++;
      wrap_up();
   end

   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_chk(ssr_pkg::OFF_CTRL, 32'h0);
      rd_chk(ssr_pkg::OFF_BUF, 32'h0);
      rd_chk(ssr_pkg::OFF_STAT, 32'h0);
      rd_chk(ssr_pkg::OFF_IEN, 32'h0);
      rd_chk(8'h14, 32'h0);
      check("pslverr", 32'h1, {31'h0, last_err});
      // disabled: clocks are ignored
      u_ssr_master_model.send_frame(8'h5A, 8);
      repeat (40) @(posedge clk);
      rd_chk(ssr_pkg::OFF_STAT, 32'h0);
      // enabled frame, irq on
      apb_xfer(1'b1, ssr_pkg::OFF_CTRL, 32'h80);
      apb_xfer(1'b1, ssr_pkg::OFF_IEN, 32'h3);
      u_ssr_master_model.send_frame(8'hA5, 8);
      wait_done();
      rd_chk(ssr_pkg::OFF_STAT, 32'h1);
      check("irq", 32'h1, {31'h0, irq});
      rd_chk(ssr_pkg::OFF_BUF, 32'hA5);
      rd_chk(ssr_pkg::OFF_CTRL, 32'h80);
      apb_xfer(1'b1, ssr_pkg::OFF_CLR, 32'h3);
      check("irq clr", 32'h0, {31'h0, irq});
      // two frames without a read of the buffer
      u_ssr_master_model.send_frame(8'h3C, 8);
      wait_done();
      u_ssr_master_model.send_frame(8'hC3, 8);
      wait_done();
      rd_chk(ssr_pkg::OFF_STAT, 32'h3);
      rd_chk(ssr_pkg::OFF_BUF, 32'hC3);
      apb_xfer(1'b1, ssr_pkg::OFF_IEN, 32'h0);
      check("irq masked", 32'h0, {31'h0, irq});
      apb_xfer(1'b1, ssr_pkg::OFF_CLR, 32'h3);
      // seven bit frame
      apb_xfer(1'b1, ssr_pkg::OFF_CTRL, 32'h81);
      u_ssr_master_model.send_frame(8'hD5, 7);
      wait_done();
      rd_chk(ssr_pkg::OFF_BUF, 32'h55);
      rd_chk(ssr_pkg::OFF_STAT, 32'h1);
      wrap_up();
   end
endmodule
`default_nettype wire
